// file: rtl/fpr_rounder.sv
// Floating-point result rounding stage with two independent rounding-control
// environments (scalar stack and SIMD), sticky exception flags and NaN handling.
// Assumes the execution core presents a normalised exact result with guard,
// round and sticky bits, and one operation per cycle with a valid strobe.
//
// Summary of operation
// - Mode 00B rounds nearest, ties to even.
// - Mode 01B rounds toward negative infinity.
// - Mode 10B rounds toward positive infinity.
// - Mode 11B truncates toward zero.
// - Reset leaves both fields at nearest.
// - Exact results pass through unchanged.
// - Pick one of two bracketing values.
// - Single format keeps 23 fraction bits.
// - Inexact rounding sets the inexact flag.
// - Compares, exact and NaN ignore mode.
// - Stack field sits in bits 10-11.
// - SIMD field sits in bits 13-14.
// - Each field governs only its unit.
// - Truncating conversions always round toward zero.
// - Reserved quiet NaN indefinite per format.
// - Six exception classes are flagged; denormal and divide come in on i_pre_exc.
// - NaN payload bits pass through untouched.
// - Signaling NaN fault reports operand address.
// - NaN quiet when top fraction bit set.
// - Quieting sets only the top fraction bit.
// - Exception flags stay set until cleared.
// - SIMD flags bits 0-5, masks 7-12.
`timescale 1ns/100ps
module fpr_rounder (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_stk_ctrl_we,
  input wire logic [15:0] i_stk_ctrl_wdata,
  input wire logic i_simd_csr_we,
  input wire logic [31:0] i_simd_csr_wdata,
  input wire logic i_valid,
  input wire logic i_is_simd,
  input wire logic [2:0] i_op_class,
  input wire logic [1:0] i_fmt,
  input wire logic i_sign,
  input wire logic [14:0] i_exp,
  input wire logic [fpr_pkg::SIG_W-1:0] i_sig,
  input wire logic i_nan_in,
  input wire logic i_gen_indef,
  input wire logic [5:0] i_pre_exc,
  input wire logic [31:0] i_operand_addr,
  output logic o_valid,
  output logic o_sign,
  output logic [14:0] o_exp,
  output logic [63:0] o_sig,
  output logic [15:0] o_stk_ctrl,
  output logic [5:0] o_stk_status,
  output logic [31:0] o_simd_control_status_reg,
  output logic o_fault,
  output logic [31:0] o_fault_addr
);
  logic [15:0] stk_ctrl_q;
  logic [5:0] stk_flags_q;
  logic [31:0] csr_q;
  logic [1:0] mode;
  logic [5:0] masks;
  logic [6:0] fw;
  logic [14:0] emax;
  logic [64:0] kept;
  logic [64:0] ulp;
  logic [64:0] sum;
  logic [63:0] lsb_mask;
  logic lsb;
  logic guard;
  logic rest;
  logic inexact;
  logic round_up;
  logic carry;
  logic [14:0] exp_r;
  logic ovf;
  logic unf;
  logic is_nan;
  logic snan;
  logic [63:0] sig_r;
  logic [14:0] exp_o;
  logic [5:0] exc;

  assign mode = (i_op_class == fpr_pkg::OP_TRUNC_CONV) ? fpr_pkg::RND_ZERO :
                i_is_simd ? csr_q[fpr_pkg::SIMD_RND_HI:fpr_pkg::SIMD_RND_LO] :
                stk_ctrl_q[fpr_pkg::STK_RND_HI:fpr_pkg::STK_RND_LO];
  assign masks = i_is_simd ? csr_q[fpr_pkg::SIMD_MASK_LO+5:fpr_pkg::SIMD_MASK_LO] :
                 stk_ctrl_q[5:0];

  always_comb begin
    case (i_fmt)
      fpr_pkg::FMT_SINGLE: begin
        fw = 7'(fpr_pkg::FRAC_S);
        emax = fpr_pkg::EMAX_S;
      end
      fpr_pkg::FMT_DOUBLE: begin
        fw = 7'(fpr_pkg::FRAC_D);
        emax = fpr_pkg::EMAX_D;
      end
      default: begin
        fw = 7'(fpr_pkg::FRAC_X);
        emax = fpr_pkg::EMAX_X;
      end
    endcase
  end

  // guard, round and sticky beyond LSB; the low three input bits are G, R, S.
  always_comb begin
    lsb_mask = 64'hFFFFFFFFFFFFFFFF << (7'd63 - fw);
    kept = {1'b0, i_sig[fpr_pkg::SIG_W-1:3] & lsb_mask};
    ulp = {1'b0, 64'h1 << (7'd63 - fw)};
    lsb = |(i_sig[fpr_pkg::SIG_W-1:3] & ulp[63:0]);
    guard = |(i_sig[fpr_pkg::SIG_W-1:3] & (ulp[63:0] >> 1)) | ((fw == 7'd63) & i_sig[2]);
    rest = |(i_sig[fpr_pkg::SIG_W-1:3] & ~lsb_mask & ~(ulp[63:0] >> 1)) |
           (fw == 7'd63 ? |i_sig[1:0] : |i_sig[2:0]);
    inexact = guard | rest;
  end

  // choose between the two bracketing values by mode.
  always_comb begin
    case (mode)
      fpr_pkg::RND_NEAREST: round_up = guard & (rest | lsb);
      fpr_pkg::RND_DOWN: round_up = inexact & i_sign;
      fpr_pkg::RND_UP: round_up = inexact & ~i_sign;
      default: round_up = 1'b0;
    endcase
  end

  // renormalise on carry-out, then check overflow.
  always_comb begin
    // exact values pass unchanged since round_up needs inexact.
    sum = kept + (round_up ? ulp : 65'h0);
    carry = sum[64];
    exp_r = carry ? i_exp + 15'h1 : i_exp;
    ovf = (exp_r >= emax);
    unf = inexact & ~i_sig[fpr_pkg::SIG_W-1] & (i_exp == 15'h0);
  end

  // quiet bit test and quieting of NaNs; payload kept.
  always_comb begin
    is_nan = i_nan_in & (i_op_class == fpr_pkg::OP_NAN || i_op_class == fpr_pkg::OP_ARITH);
    // The top fraction bit sits just below the integer bit.
    snan = is_nan & ~i_sig[fpr_pkg::SIG_W-2];
    sig_r = carry ? {1'b1, sum[63:1]} : sum[63:0];
    exp_o = exp_r;
    // quiet NaN indefinite: integer bit and top fraction bit set.
    if (i_gen_indef) begin
      sig_r = 64'hC000000000000000;
      exp_o = emax;
    end else if (is_nan) begin
      sig_r = i_sig[fpr_pkg::SIG_W-1:3] | 64'h4000000000000000;
      exp_o = emax;
    end else if (i_op_class == fpr_pkg::OP_COMPARE) begin
      sig_r = i_sig[fpr_pkg::SIG_W-1:3];
      exp_o = i_exp;
    end
  end

  // six exception classes; inexact when the value changed.
  always_comb begin
    exc = i_pre_exc;
    exc[fpr_pkg::EX_INV] = i_pre_exc[fpr_pkg::EX_INV] | snan | i_gen_indef;
    if (!is_nan && !i_gen_indef && i_op_class != fpr_pkg::OP_COMPARE) begin
      exc[fpr_pkg::EX_INX] = i_pre_exc[fpr_pkg::EX_INX] | inexact;
      exc[fpr_pkg::EX_OVF] = i_pre_exc[fpr_pkg::EX_OVF] | ovf;
      exc[fpr_pkg::EX_UNF] = i_pre_exc[fpr_pkg::EX_UNF] | unf;
    end
  end

  // scalar stack control word; default rounding is nearest.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stk_ctrl_q <= fpr_pkg::STK_CTRL_RESET;
    end else if (i_stk_ctrl_we) begin
      stk_ctrl_q <= i_stk_ctrl_wdata;
    end
  end

  // stack flags are sticky; a new event wins over a same-cycle write.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stk_flags_q <= 6'h00;
    end else begin
      stk_flags_q <= (i_stk_ctrl_we ? 6'h00 : stk_flags_q) |
                     ((i_valid && !i_is_simd) ? exc : 6'h00);
    end
  end

  // SIMD register, flags sticky with set winning over clear.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      csr_q <= fpr_pkg::SIMD_CSR_RESET;
    end else begin
      csr_q <= (i_simd_csr_we ? {16'h0000, i_simd_csr_wdata[15:0]} : csr_q) |
               ((i_valid && i_is_simd) ? {26'h0, exc} : 32'h0);
    end
  end

  // Registered result; data outputs come straight from flops.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_sign <= 1'b0;
      o_exp <= 15'h0;
      o_sig <= 64'h0;
    end else begin
      o_valid <= i_valid & ~(|(exc & ~masks));
      o_sign <= i_sign;
      o_exp <= exp_o;
      o_sig <= sig_r;
    end
  end

  // unmasked exception faults with the offending operand address.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_fault <= 1'b0;
      o_fault_addr <= 32'h0;
    end else begin
      o_fault <= i_valid & (|(exc & ~masks));
      if (i_valid && |(exc & ~masks)) begin
        o_fault_addr <= i_operand_addr;
      end
    end
  end

  assign o_stk_ctrl = stk_ctrl_q;
  assign o_stk_status = stk_flags_q;
  assign o_simd_control_status_reg = csr_q;
endmodule : fpr_rounder

// file: rtl/fpr_pkg.sv
// Constants shared by the floating-point rounding stage.
// Assumes a single core clock and a synchronous active-low reset.
package fpr_pkg;
  // Rounding-control encodings.
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_DOWN = 2'h1;
  localparam logic [1:0] RND_UP = 2'h2;
  localparam logic [1:0] RND_ZERO = 2'h3;
  localparam logic [1:0] RND_RESET = 2'h0;
  // Field positions in the scalar stack control word.
  localparam int STK_RND_LO = 10;
  localparam int STK_RND_HI = 11;
  localparam logic [15:0] STK_CTRL_RESET = 16'h037F;
  // Field positions in the SIMD control and status register.
  localparam int SIMD_FLAG_LO = 0;
  localparam int SIMD_MASK_LO = 7;
  localparam int SIMD_RND_LO = 13;
  localparam int SIMD_RND_HI = 14;
  localparam logic [31:0] SIMD_CSR_RESET = 32'h00001F80;
  // Exception flag order inside a six-bit group.
  localparam int EX_INV = 0;
  localparam int EX_DEN = 1;
  localparam int EX_DIV = 2;
  localparam int EX_OVF = 3;
  localparam int EX_UNF = 4;
  localparam int EX_INX = 5;
  localparam int EX_NUM = 6;
  // Destination formats.
  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_EXT = 2'h2;
  // Fraction widths and maximum biased exponents per format.
  localparam int FRAC_S = 23;
  localparam int FRAC_D = 52;
  localparam int FRAC_X = 63;
  localparam logic [14:0] EMAX_S = 15'h00FF;
  localparam logic [14:0] EMAX_D = 15'h07FF;
  localparam logic [14:0] EMAX_X = 15'h7FFF;
  // Width of the incoming significand: integer bit, 63 fraction bits, guard, round, sticky.
  localparam int SIG_W = 67;
  // Operation classes seen by the rounder.
  localparam logic [2:0] OP_ARITH = 3'h0;
  localparam logic [2:0] OP_COMPARE = 3'h1;
  localparam logic [2:0] OP_TRUNC_CONV = 3'h2;
  localparam logic [2:0] OP_NAN = 3'h3;
endpackage : fpr_pkg

// file: test/fpr_rounder_props.sv
// Port assertions for the rounding stage.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module fpr_rounder_chk (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_stk_ctrl_we,
  input wire logic [15:0] i_stk_ctrl_wdata,
  input wire logic i_simd_csr_we,
  input wire logic [31:0] i_simd_csr_wdata,
  input wire logic i_valid,
  input wire logic i_is_simd,
  input wire logic [2:0] i_op_class,
  input wire logic [1:0] i_fmt,
  input wire logic [fpr_pkg::SIG_W-1:0] i_sig,
  input wire logic i_nan_in,
  input wire logic i_gen_indef,
  input wire logic [5:0] i_pre_exc,
  input wire logic o_valid,
  input wire logic o_fault,
  input wire logic [63:0] o_sig,
  input wire logic [15:0] o_stk_ctrl,
  input wire logic [5:0] o_stk_status,
  input wire logic [31:0] o_simd_control_status_reg
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // A plain single stack operation, so no special case can interfere.
  logic plain;
  assign plain = i_valid && !i_is_simd && i_op_class == fpr_pkg::OP_ARITH && i_sig[66] &&
    i_fmt == fpr_pkg::FMT_SINGLE && !i_nan_in && !i_gen_indef && i_pre_exc == 6'h00;
  property p_rst; disable iff (1'b0) !i_rst_n |=> o_stk_ctrl == fpr_pkg::STK_CTRL_RESET &&
    o_simd_control_status_reg == fpr_pkg::SIMD_CSR_RESET; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_take; i_valid |=> o_valid != o_fault; endproperty
  a_take: assert property (p_take) else $error("no single answer");
  property p_idle; !i_valid |=> !o_valid && !o_fault; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_stk; i_stk_ctrl_we |=> o_stk_ctrl[11:10] == $past(i_stk_ctrl_wdata[11:10]);
  endproperty
  a_stk: assert property (p_stk) else $error("stack mode not stored");
  property p_simd; i_simd_csr_we && !i_valid |=>
    o_simd_control_status_reg[14:7] == $past(i_simd_csr_wdata[14:7]); endproperty
  a_simd: assert property (p_simd) else $error("SIMD field not stored");
  property p_stick; o_stk_status[5] && !i_stk_ctrl_we |=> o_stk_status[5]; endproperty
  a_stick: assert property (p_stick) else $error("inexact flag lost");
  property p_inx; plain && i_sig[42:0] != 43'h0 |=> o_stk_status[5]; endproperty
  a_inx: assert property (p_inx) else $error("inexact flag not set");
  property p_exact; plain && i_sig[42:0] == 43'h0 |=>
    o_valid && o_sig[63:40] == $past(i_sig[66:43]); endproperty
  a_exact: assert property (p_exact) else $error("exact value altered");
  c_tie: cover property (plain && i_sig[42:0] == 43'h400_0000_0000);
  c_carry: cover property (plain && i_sig[66:43] == 24'hFFFFFF);
  c_trunc: cover property (i_valid && i_op_class == fpr_pkg::OP_TRUNC_CONV);
endmodule : fpr_rounder_chk
bind fpr_rounder fpr_rounder_chk i_fpr_rounder_chk (.*);

// file: test/fpr_core_model.sv
// Execution core stand-in that presents one operation per call.
// Assumes the caller enters the task just after a rising edge.
`timescale 1ns/100ps
module fpr_core_model (
  input wire logic i_clock,
  output logic o_valid,
  output logic o_is_simd,
  output logic [2:0] o_op_class,
  output logic o_sign,
  output logic [fpr_pkg::SIG_W-1:0] o_sig
);
  initial {o_valid, o_is_simd, o_op_class, o_sign, o_sig} = '0;
  // Valid stands for exactly one taking edge, then drops.
  task automatic issue(input logic s, input logic [2:0] c, input logic g,
    input logic [fpr_pkg::SIG_W-1:0] v);
    o_is_simd <= s;
    o_op_class <= c;
    o_sign <= g;
    o_sig <= v;
    o_valid <= 1'b1;
    @(posedge i_clock);
    o_valid <= 1'b0;
  endtask : issue
endmodule : fpr_core_model

// file: test/tb_fpr_rounder.sv
// Self-checking bench for the rounding stage, single format, all four modes.
// Assumes the design answers at the taking edge itself, from registered outputs.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_fpr_rounder;
  logic i_clock, i_rst_n, swe, cwe, pv, ps, pg, o_valid, o_sign, inc, inx, sm, fs, fv;
  logic nan, gind, fo;
  logic [15:0] swd, o_stk_ctrl;
  logic [31:0] cwd, addr, x, r, o_csr, fa;
  logic [2:0] pc, cl;
  logic [1:0] md;
  logic [14:0] o_exp;
  logic [5:0] o_stk_status;
  logic [63:0] o_sig;
  logic [66:0] pd;
  logic [23:0] t;
  logic [42:0] rem;
  logic [24:0] s;
  int fails = 0;
  int num_checks = 0;
  fpr_core_model i_fpr_core_model (.i_clock(i_clock), .o_valid(pv), .o_is_simd(ps),
    .o_op_class(pc), .o_sign(pg), .o_sig(pd));
  fpr_rounder i_fpr_rounder (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_stk_ctrl_we(swe),
    .i_stk_ctrl_wdata(swd), .i_simd_csr_we(cwe), .i_simd_csr_wdata(cwd), .i_valid(pv),
    .i_is_simd(ps), .i_op_class(pc), .i_fmt(fpr_pkg::FMT_SINGLE), .i_sign(pg),
    .i_exp(15'h0040), .i_sig(pd), .i_nan_in(nan), .i_gen_indef(gind), .i_pre_exc(6'h00),
    .i_operand_addr(addr), .o_valid(o_valid), .o_sign(o_sign), .o_exp(o_exp), .o_sig(o_sig),
    .o_stk_ctrl(o_stk_ctrl), .o_stk_status(o_stk_status), .o_simd_control_status_reg(o_csr),
    .o_fault(fo), .o_fault_addr(fa));
  // Xorshift source with a fixed start.
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  // Single place where the run ends.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Hang guard, far beyond the 500 or so cycles the run needs.
  initial begin
    repeat (4000) @(posedge i_clock);
    fails++;
    close_out();
  end
  // Stack and SIMD get opposite modes so a crossed field shows up.
  initial begin
    {x, i_rst_n, swe, cwe, swd, cwd, addr} = {32'h6B11, 83'h0};
    {nan, gind} = 2'h0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    #1;
    `CHK("stk ctrl", 16'h037F, o_stk_ctrl)
    `CHK("simd csr", 32'h00001F80, o_csr)
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clock);
      {swe, cwe} <= 2'h3;
      swd <= 16'h037F | (16'(m) << 10);
      cwd <= 32'h00001F80 | (32'(3 - m) << 13);
      @(posedge i_clock);
      {swe, cwe} <= 2'h0;
      {fs, fv} = 2'h0;
      #1;
      `CHK("stk mode", 2'(m), o_stk_ctrl[11:10])
      `CHK("simd mode", 2'(3 - m), o_csr[14:13])
      repeat (60) begin
        @(posedge i_clock);
        r = rnd();
        sm = r[0];
        cl = (sm && r[1]) ? fpr_pkg::OP_TRUNC_CONV : fpr_pkg::OP_ARITH;
        t = (r[3:2] == 2'h0) ? 24'hFFFFFF : {1'b1, 23'(rnd())};
        rem = (r[5:4] == 2'h0) ? 43'h400_0000_0000 : (r[5:4] == 2'h1) ? 43'h0 : {11'(rnd()), rnd()};
        addr <= rnd();
        md = (cl == fpr_pkg::OP_TRUNC_CONV) ? 2'h3 : sm ? 2'(3 - m) : 2'(m);
        inx = |rem;
        case (md)
          2'h0: inc = rem[42] && ((|rem[41:0]) || t[0]);
          2'h1: inc = r[6] && inx;
          2'h2: inc = !r[6] && inx;
          default: inc = 1'b0;
        endcase
        s = {1'b0, t} + 25'(inc);
        if (sm) fv = fv | inx;
        else fs = fs | inx;
        i_fpr_core_model.issue(sm, cl, r[6], {t, rem});
        #1;
        `CHK("valid", 1'b1, o_valid)
        `CHK("sign", r[6], o_sign)
        `CHK("sig", s[24] ? 64'h8000000000000000 : {s[23:0], 40'h0}, o_sig)
        `CHK("exp", s[24] ? 15'h0041 : 15'h0040, o_exp)
        `CHK("inexact", sm ? fv : fs, sm ? o_csr[5] : o_stk_status[5])
      end
    end
    // Unmask invalid on the stack so a signaling NaN must fault.
    @(posedge i_clock);
    swe <= 1'b1;
    swd <= 16'h037E;
    @(posedge i_clock);
    swe <= 1'b0;
    nan <= 1'b1;
    addr <= 32'h00001234;
    i_fpr_core_model.issue(1'b0, fpr_pkg::OP_ARITH, 1'b0, {3'h4, 64'h0000000000000AB8});
    nan <= 1'b0;
    #1;
    `CHK("fault", 1'b1, fo)
    `CHK("nan valid", 1'b0, o_valid)
    `CHK("fault addr", 32'h00001234, fa)
    `CHK("quiet sig", 64'hC000000000000157, o_sig)
    `CHK("nan exp", 15'h00FF, o_exp)
    `CHK("stk flags", 6'h01, o_stk_status)
    // Masked SIMD indefinite result.
    gind <= 1'b1;
    i_fpr_core_model.issue(1'b1, fpr_pkg::OP_ARITH, 1'b0, 67'h0);
    gind <= 1'b0;
    #1;
    `CHK("indef valid", 1'b1, o_valid)
    `CHK("indef sig", 64'hC000000000000000, o_sig)
    `CHK("indef exp", 15'h00FF, o_exp)
    `CHK("simd inv", 1'b1, o_csr[0])
    close_out();
  end
endmodule : tb_fpr_rounder
